/* File: hdl/apl_addr_map.sv */
/*
  Routes a 16-bit data address to external memory or an on-chip block.
  Purely combinational; the caller passes the outputs out unqualified by its dataRead strobe.
*/
`timescale 1ns/1ps
module apl_addr_map (
  input  wire logic [15:0] addr,
  output logic             toExternal,
  output logic             toBlock01,
  output logic             toBlock2
);
  logic [8:0] page;
  assign page = addr[15:7];

  // ==========================================================================
  // page routing
  always_comb begin
    toExternal = (page >= apl_pkg::PAGE_EXT_MIN);
    toBlock01  = (page >= apl_pkg::PAGE_B01_LO) && (page <= apl_pkg::PAGE_B01_HI);
    toBlock2   = (page == apl_pkg::PAGE_BLK2) && (addr[6:0] >= apl_pkg::BLK2_OFS_MIN);
  end
endmodule : apl_addr_map

/* File: hdl/apl_aux_regs.sv */
/*
  Eight auxiliary registers with one write port and two read ports.
  Assumes the controller never writes two registers in one cycle.
*/
`timescale 1ns/1ps
module apl_aux_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wrEn,
  input  wire logic [2:0]  wrSel,
  input  wire logic [15:0] wrData,
  input  wire logic [2:0]  rdSelA,
  output logic      [15:0] rdDataA,
  input  wire logic [2:0]  rdSelB,
  output logic      [15:0] rdDataB
);
  logic [15:0] aux_reg [8];

  // ==========================================================================
  // register array
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_aux
      logic [15:0] aux_next;
      always_comb begin
        aux_next = aux_reg[i];
        if (wrEn && wrSel == 3'(i)) begin
          aux_next = wrData;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          aux_reg[i] <= 16'h0000;
        end else begin
          aux_reg[i] <= aux_next;
        end
      end
    end
  endgenerate

  assign rdDataA = aux_reg[rdSelA];
  assign rdDataB = aux_reg[rdSelB];
endmodule : apl_aux_regs

/* File: hdl/apl_load_unit.sv */
/*
  Executes the auxiliary, pointer, page and product-high load instructions.
  Assumes memData answers a dataRead one cycle later and comes from this
  clock domain; the repeat count is given together with the instruction.
*/
`timescale 1ns/1ps
module apl_load_unit (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  output logic             instrReady,
  input  wire logic [7:0]  rptCount,
  input  wire logic        progExternal,
  input  wire logic [3:0]  progWaits,
  output logic             dataRead,
  output logic      [15:0] dataAddr,
  input  wire logic [15:0] memData,
  output logic             toExternal,
  output logic             toBlock01,
  output logic             toBlock2,
  input  wire logic        mulLoad,
  input  wire logic [31:0] mulProduct,
  input  wire logic [2:0]  auxSel,
  output logic      [15:0] auxValue,
  output logic      [2:0]  auxPointer,
  output logic      [2:0]  auxBuffer,
  output logic      [8:0]  dataPage,
  output logic             signExtMode,
  output logic      [15:0] progCounter,
  output logic      [31:0] productReg,
  output logic             repeatRefused
);
  // ==========================================================================
  // decoding
  function automatic apl_pkg::apl_op_e decodeOp(input logic [15:0] w);
    if (w[15:11] == apl_pkg::OP_AUX_MEM) begin
      decodeOp = apl_pkg::K_AUX_MEM;
    end else if (w[15:11] == apl_pkg::OP_AUX_SHORT) begin
      decodeOp = apl_pkg::K_AUX_SHORT;
    end else if (w[15:11] == apl_pkg::OP_AUX_LONG && w[7:0] == 8'h00) begin
      decodeOp = apl_pkg::K_AUX_LONG;
    end else if (w[15:9] == apl_pkg::OP_PAGE_IMM) begin
      decodeOp = apl_pkg::K_PAGE_IMM;
    end else begin
      case (w[15:8])
        apl_pkg::OP_STAT_ZERO: decodeOp = apl_pkg::K_STAT_ZERO;
        apl_pkg::OP_STAT_ONE:  decodeOp = apl_pkg::K_STAT_ONE;
        apl_pkg::OP_PAGE_MEM:  decodeOp = apl_pkg::K_PAGE_MEM;
        apl_pkg::OP_PROD_HIGH: decodeOp = apl_pkg::K_PROD_HIGH;
        apl_pkg::OP_MOD_AUX:   decodeOp = apl_pkg::K_MOD_AUX;
        default:          decodeOp = apl_pkg::K_NONE;
      endcase
    end
  endfunction : decodeOp

  function automatic logic canRepeat(input apl_pkg::apl_op_e k);
    canRepeat = !(k == apl_pkg::K_AUX_SHORT || k == apl_pkg::K_PAGE_IMM ||
                  k == apl_pkg::K_AUX_LONG || k == apl_pkg::K_NONE);
  endfunction : canRepeat

  apl_pkg::apl_state_e state_reg, state_next;
  logic [15:0] instr_reg, instr_next, pc_reg, pc_next;
  logic [7:0]  rpt_reg, rpt_next;
  logic [4:0]  wait_reg, wait_next;
  logic [2:0]  ptr_reg, ptr_next, pbuf_reg, pbuf_next;
  logic [8:0]  page_reg, page_next;
  logic        sign_reg, sign_next;
  logic [31:0] prod_reg, prod_next;

  logic [15:0] cur, auxCur, auxWrData;
  logic [2:0]  auxWrSel;
  logic        auxWrEn, execOn, finish, isMem;
  logic [4:0]  finWaits;
  apl_pkg::apl_op_e op, memOp;

  assign cur    = (state_reg == apl_pkg::ST_IDLE) ? instrWord : instr_reg;
  assign op     = decodeOp(cur);
  assign memOp  = decodeOp(instr_reg);
  assign execOn = (state_reg == apl_pkg::ST_IDLE && instrValid) ||
                  (state_reg == apl_pkg::ST_ISSUE);
  assign isMem  = op == apl_pkg::K_AUX_MEM || op == apl_pkg::K_PAGE_MEM ||
                  op == apl_pkg::K_PROD_HIGH || op == apl_pkg::K_STAT_ZERO ||
                  op == apl_pkg::K_STAT_ONE;
  assign dataAddr = cur[apl_pkg::IND_BIT] ? auxCur : {page_reg, cur[6:0]};

  apl_aux_regs u_aux (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (auxWrEn),
    .wrSel   (auxWrSel),
    .wrData  (auxWrData),
    .rdSelA  (ptr_reg),
    .rdDataA (auxCur),
    .rdSelB  (auxSel),
    .rdDataB (auxValue)
  );

  apl_addr_map u_map (
    .addr       (dataAddr),
    .toExternal (toExternal),
    .toBlock01  (toBlock01),
    .toBlock2   (toBlock2)
  );

  // ==========================================================================
  // execution control
  always_comb begin
    state_next = state_reg;
    instr_next = instr_reg;
    rpt_next   = rpt_reg;
    wait_next  = wait_reg;
    ptr_next   = ptr_reg;
    pbuf_next  = pbuf_reg;
    page_next  = page_reg;
    sign_next  = sign_reg;
    pc_next    = pc_reg;
    prod_next  = mulLoad ? mulProduct : prod_reg;
    auxWrEn    = 1'b0;
    auxWrSel   = ptr_reg;
    auxWrData  = auxCur;
    dataRead   = 1'b0;
    instrReady = 1'b0;
    repeatRefused = 1'b0;
    finish     = 1'b0;
    finWaits   = {1'b0, progWaits};
    case (state_reg)
      apl_pkg::ST_IDLE, apl_pkg::ST_ISSUE: begin
        instrReady = (state_reg == apl_pkg::ST_IDLE);
        if (execOn) begin
          if (state_reg == apl_pkg::ST_IDLE) begin
            instr_next = instrWord;
            rpt_next = canRepeat(op) ? rptCount : 8'h00;
            repeatRefused = !canRepeat(op) && rptCount != 8'h00;
            pc_next = pc_reg + ((op == apl_pkg::K_AUX_LONG) ? apl_pkg::PC_STEP_LONG
                                                            : apl_pkg::PC_STEP_SHORT);
          end
          if (cur[apl_pkg::IND_BIT] && (isMem || op == apl_pkg::K_MOD_AUX)) begin
            if ((cur[apl_pkg::INC_BIT] || cur[apl_pkg::DEC_BIT]) &&
                !(op == apl_pkg::K_AUX_MEM && cur[10:8] == ptr_reg)) begin
              auxWrEn   = 1'b1;
              auxWrData = cur[apl_pkg::INC_BIT] ? auxCur + 16'h0001 : auxCur - 16'h0001;
            end
            if (cur[apl_pkg::NARP_BIT] && op != apl_pkg::K_STAT_ZERO &&
                op != apl_pkg::K_STAT_ONE) begin
              pbuf_next = ptr_reg;
              ptr_next  = cur[2:0];
            end
          end
          case (op)
            apl_pkg::K_AUX_SHORT: begin
              auxWrEn   = 1'b1;
              auxWrSel  = cur[10:8];
              auxWrData = {8'h00, cur[7:0]};
              finish    = 1'b1;
            end
            apl_pkg::K_PAGE_IMM: begin
              page_next = cur[8:0];
              finish    = 1'b1;
            end
            apl_pkg::K_AUX_LONG: begin
              state_next = apl_pkg::ST_LONG;
            end
            apl_pkg::K_MOD_AUX, apl_pkg::K_NONE: begin
              finish = 1'b1;
            end
            default: begin
              dataRead   = 1'b1;
              state_next = apl_pkg::ST_MEM;
            end
          endcase
        end
      end
      apl_pkg::ST_MEM: begin
        finish = 1'b1;
        case (memOp)
          apl_pkg::K_AUX_MEM: begin
            auxWrEn   = 1'b1;
            auxWrSel  = instr_reg[10:8];
            auxWrData = memData;
          end
          apl_pkg::K_PAGE_MEM:  page_next = memData[8:0];
          apl_pkg::K_PROD_HIGH: prod_next[31:16] = memData;
          apl_pkg::K_STAT_ZERO: begin
            ptr_next  = memData[apl_pkg::PTR_HI:apl_pkg::PTR_LO];
            page_next = memData[8:0];
          end
          apl_pkg::K_STAT_ONE: begin
            pbuf_next = memData[apl_pkg::PTR_HI:apl_pkg::PTR_LO];
            ptr_next  = memData[apl_pkg::PTR_HI:apl_pkg::PTR_LO];
            sign_next = memData[apl_pkg::SIGN_BIT];
          end
          default: begin
          end
        endcase
      end
      apl_pkg::ST_LONG: begin
        instrReady = 1'b1;
        if (instrValid) begin
          auxWrEn   = 1'b1;
          auxWrSel  = instr_reg[10:8];
          auxWrData = instrWord;
          finish    = 1'b1;
          finWaits  = {progWaits, 1'b0};
        end
      end
      apl_pkg::ST_WAIT: begin
        wait_next = wait_reg - 5'h01;
        if (wait_reg == 5'h01) begin
          state_next = apl_pkg::ST_IDLE;
        end
      end
      default: state_next = apl_pkg::ST_IDLE;
    endcase
    if (finish) begin
      if (rpt_next != 8'h00) begin
        rpt_next   = rpt_next - 8'h01;
        state_next = apl_pkg::ST_ISSUE;
      end else if (progExternal && finWaits != 5'h00) begin
        wait_next  = finWaits;
        state_next = apl_pkg::ST_WAIT;
      end else begin
        state_next = apl_pkg::ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= apl_pkg::ST_IDLE;
      instr_reg <= 16'h0000;
      rpt_reg   <= 8'h00;
      wait_reg  <= 5'h00;
      ptr_reg   <= apl_pkg::PTR_RST;
      pbuf_reg  <= apl_pkg::PTR_RST;
      page_reg  <= apl_pkg::PAGE_RST;
      sign_reg  <= apl_pkg::SIGN_RST;
      pc_reg    <= apl_pkg::PC_RST;
      prod_reg  <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      rpt_reg   <= rpt_next;
      wait_reg  <= wait_next;
      ptr_reg   <= ptr_next;
      pbuf_reg  <= pbuf_next;
      page_reg  <= page_next;
      sign_reg  <= sign_next;
      pc_reg    <= pc_next;
      prod_reg  <= prod_next;
    end
  end

  assign auxPointer  = ptr_reg;
  assign auxBuffer   = pbuf_reg;
  assign dataPage    = page_reg;
  assign signExtMode = sign_reg;
  assign progCounter = pc_reg;
  assign productReg  = prod_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence longStart;
    execOn && state_reg == apl_pkg::ST_IDLE && op == apl_pkg::K_AUX_LONG && !progExternal;
  endsequence
  sequence longSecond;
    instrValid && state_reg == apl_pkg::ST_LONG;
  endsequence

  aux_no_modify_a : assert property (
    execOn && op == apl_pkg::K_AUX_MEM && cur[apl_pkg::IND_BIT] && cur[10:8] == ptr_reg
    |-> !auxWrEn) else $error("pointed register modified by aux load");
  short_zero_fill_a : assert property (
    execOn && op == apl_pkg::K_AUX_SHORT |-> auxWrEn && auxWrSel == cur[10:8] &&
    auxWrData == {8'h00, cur[7:0]}) else $error("short aux load not zero filled");
  ptr_buffer_a : assert property (
    execOn && op == apl_pkg::K_MOD_AUX && cur[apl_pkg::IND_BIT] && cur[apl_pkg::NARP_BIT]
    |=> pbuf_reg == $past(ptr_reg) && ptr_reg == $past(cur[2:0]))
    else $error("pointer buffer not loaded");
  page_nine_a : assert property (
    state_reg == apl_pkg::ST_MEM && memOp == apl_pkg::K_PAGE_MEM |=>
    page_reg == $past(memData[8:0])) else $error("page load wrong");
  direct_addr_a : assert property (
    dataRead && !cur[apl_pkg::IND_BIT] |-> dataAddr[15:7] == page_reg &&
    dataAddr[6:0] == cur[6:0]) else $error("direct address wrong");
  page_imm_a : assert property (
    execOn && op == apl_pkg::K_PAGE_IMM |=> page_reg == $past(cur[8:0]))
    else $error("page immediate wrong");
  ext_route_a : assert property (
    dataRead && !cur[apl_pkg::IND_BIT] && page_reg >= apl_pkg::PAGE_EXT_MIN |->
    toExternal && !toBlock01 && !toBlock2) else $error("external page not routed out");
  long_cycles_a : assert property (
    longStart ##1 longSecond |=> state_reg == apl_pkg::ST_IDLE)
    else $error("long load not two cycles");
  sign_kept_a : assert property (
    longStart ##1 longSecond |=> $stable(sign_reg)) else $error("sign mode changed");
  no_repeat_a : assert property (
    execOn && (op == apl_pkg::K_AUX_SHORT || op == apl_pkg::K_PAGE_IMM) |=>
    state_reg != apl_pkg::ST_ISSUE) else $error("short load repeated");
  lph_low_a : assert property (
    state_reg == apl_pkg::ST_MEM && memOp == apl_pkg::K_PROD_HIGH && !mulLoad |=>
    prod_reg[15:0] == $past(prod_reg[15:0]) && prod_reg[31:16] == $past(memData))
    else $error("product high load wrong");
  pc_long_a : assert property (
    execOn && state_reg == apl_pkg::ST_IDLE && op == apl_pkg::K_AUX_LONG |=>
    pc_reg == $past(pc_reg) + apl_pkg::PC_STEP_LONG) else $error("pc step wrong");
endmodule : apl_load_unit

/* File: include/apl_pkg.sv */
/*
  Constants, opcode patterns and types of the auxiliary pointer and page
  load unit. Assumes a core that fetches one 16-bit word per cycle.
*/
package apl_pkg;
  // ==========================================================================
  // widths and opcode patterns
  localparam int unsigned AUX_W = 16;
  localparam int unsigned PAGE_W = 9;
  localparam logic [4:0] OP_AUX_MEM    = 5'h06;
  localparam logic [4:0] OP_AUX_SHORT  = 5'h18;
  localparam logic [4:0] OP_AUX_LONG   = 5'h1a;
  localparam logic [6:0] OP_PAGE_IMM   = 7'h64;
  localparam logic [7:0] OP_STAT_ZERO  = 8'h50;
  localparam logic [7:0] OP_STAT_ONE   = 8'h51;
  localparam logic [7:0] OP_PAGE_MEM   = 8'h52;
  localparam logic [7:0] OP_PROD_HIGH  = 8'h53;
  localparam logic [7:0] OP_MOD_AUX    = 8'h55;
  // ==========================================================================
  // field positions
  localparam int unsigned IND_BIT  = 7;
  localparam int unsigned INC_BIT  = 5;
  localparam int unsigned DEC_BIT  = 4;
  localparam int unsigned NARP_BIT = 3;
  localparam int unsigned PTR_HI   = 15;
  localparam int unsigned PTR_LO   = 13;
  localparam int unsigned SIGN_BIT = 10;
  // ==========================================================================
  // memory map
  localparam logic [8:0] PAGE_EXT_MIN = 9'h008;
  localparam logic [8:0] PAGE_B01_LO  = 9'h004;
  localparam logic [8:0] PAGE_B01_HI  = 9'h007;
  localparam logic [8:0] PAGE_BLK2    = 9'h000;
  localparam logic [6:0] BLK2_OFS_MIN = 7'h60;
  // ==========================================================================
  // reset values and timing
  localparam logic [2:0]  PTR_RST  = 3'h0;
  localparam logic [8:0]  PAGE_RST = 9'h000;
  localparam logic        SIGN_RST = 1'b1;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] PC_STEP_SHORT = 16'h0001;
  localparam logic [15:0] PC_STEP_LONG  = 16'h0002;
  localparam int unsigned LONG_CYCLES   = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ISSUE = 3'b001,
    ST_MEM   = 3'b010,
    ST_LONG  = 3'b011,
    ST_WAIT  = 3'b100
  } apl_state_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_AUX_MEM = 4'h1, K_AUX_SHORT = 4'h2, K_MOD_AUX = 4'h3,
    K_PAGE_MEM = 4'h4, K_PAGE_IMM = 4'h5, K_PROD_HIGH = 4'h6, K_AUX_LONG = 4'h7,
    K_STAT_ZERO = 4'h8, K_STAT_ONE = 4'h9
  } apl_op_e;
endpackage : apl_pkg

/* File: verif/apl_load_unit_tb.sv */
/*
  Self-checking bench for the auxiliary pointer and page load unit.
  Assumes a single 20 MHz clock and that memData answers the cycle after
  a read; the bench plays both the fetch side and the data memory.
*/
`timescale 1ns/1ps
module apl_load_unit_tb;
  logic        sys_clk;
  logic        rst_n;
  logic        instrValid;
  logic [15:0] instrWord;
  logic        instrReady;
  logic [7:0]  rptCount;
  logic        progExternal;
  logic [3:0]  progWaits;
  logic        dataRead;
  logic [15:0] dataAddr;
  logic [15:0] memData;
  logic        toExternal;
  logic        toBlock01;
  logic        toBlock2;
  logic        mulLoad;
  logic [31:0] mulProduct;
  logic [2:0]  auxSel;
  logic [15:0] auxValue;
  logic [2:0]  auxPointer;
  logic [2:0]  auxBuffer;
  logic [8:0]  dataPage;
  logic        signExtMode;
  logic [15:0] progCounter;
  logic [31:0] productReg;
  logic        repeatRefused;
  int          num_errors;
  int          comparisons;
  int          lowCnt;
  logic        seenRead;
  logic        seenRef;
  logic        seenExt;
  logic        seenB01;
  logic        seenB2;
  logic [15:0] seenAddr;
  logic [15:0] expPc;
  localparam logic [8:0] PG [5] = '{9'h008, 9'h004, 9'h007, 9'h000, 9'h000};
  localparam logic [6:0] OF [5] = '{7'h00, 7'h10, 7'h7f, 7'h60, 7'h5f};

  apl_load_unit dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .rptCount(rptCount), .progExternal(progExternal),
    .progWaits(progWaits), .dataRead(dataRead), .dataAddr(dataAddr), .memData(memData),
    .toExternal(toExternal), .toBlock01(toBlock01), .toBlock2(toBlock2),
    .mulLoad(mulLoad), .mulProduct(mulProduct), .auxSel(auxSel), .auxValue(auxValue),
    .auxPointer(auxPointer), .auxBuffer(auxBuffer), .dataPage(dataPage),
    .signExtMode(signExtMode), .progCounter(progCounter), .productReg(productReg),
    .repeatRefused(repeatRefused)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // access tasks
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // counts cycles with the unit busy; bounded so a stuck unit ends the run
  task automatic wait_ready;
    lowCnt = 0;
    #1;
    while (instrReady !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      lowCnt++;
      if (lowCnt > 100) begin
        num_errors++;
        $display("[ERR] %0t ready never returned", $time);
        test_done();
      end
    end
  endtask : wait_ready

  task automatic issue(input logic [15:0] word, input logic [7:0] rpt, input logic [15:0] d);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord  <= word;
    rptCount   <= rpt;
    wait_ready();
    seenRead = dataRead;
    seenRef  = repeatRefused;
    seenExt  = toExternal;
    seenB01  = toBlock01;
    seenB2   = toBlock2;
    seenAddr = dataAddr;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    memData    <= d;
    wait_ready();
  endtask : issue

  task automatic op(input logic [15:0] w, input logic [7:0] r, input logic [15:0] d,
                    input logic [15:0] step);
    issue(w, r, d);
    expPc = expPc + step;
    chk(progCounter, expPc);
  endtask : op

  task automatic chk_aux(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge sys_clk);
    auxSel <= sel;
    @(posedge sys_clk);
    #1;
    chk(auxValue, exp);
  endtask : chk_aux

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0; instrValid = 1'b0; instrWord = 16'h0000; rptCount = 8'h00;
    progExternal = 1'b0; progWaits = 4'h0; memData = 16'h0000; mulLoad = 1'b0;
    mulProduct = 32'h00000000; auxSel = 3'h0; num_errors = 0; comparisons = 0;
    expPc = 16'h0000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({auxPointer, auxBuffer, dataPage, signExtMode}, 16'h0001);
    chk(productReg, 32'h00000000);
    // top bit of each constant set, so sign extension would show
    for (int i = 0; i < 8; i++) begin
      op({apl_pkg::OP_AUX_SHORT, i[2:0], 8'h80 | i[7:0]}, 8'h00, 16'h0000, 16'h0001);
      chk({seenRef, lowCnt[3:0]}, 5'h00);
    end
    for (int i = 0; i < 8; i++) chk_aux(i[2:0], 16'h0080 | i[15:0]);
    op({apl_pkg::OP_AUX_SHORT, 3'd0, 8'h11}, 8'h03, 16'h0000, 16'h0001);
    chk(seenRef, 1'b1);
    chk_aux(3'd0, 16'h0011);
    op({apl_pkg::OP_PAGE_IMM, 9'h1ff}, 8'h01, 16'h0000, 16'h0001);
    chk({seenRef, dataPage}, {1'b1, 9'h1ff});
    op(16'h558d, 8'h00, 16'h0000, 16'h0001);
    chk({auxBuffer, auxPointer}, {3'd0, 3'd5});
    // every iteration buffers the pointer, so the last copy is the new one
    op(16'h558a, 8'h02, 16'h0000, 16'h0001);
    chk({seenRef, auxBuffer, auxPointer}, {1'b0, 3'd2, 3'd2});
    op({apl_pkg::OP_MOD_AUX, 8'hae}, 8'h00, 16'h0000, 16'h0001);
    chk({auxBuffer, auxPointer}, {3'd2, 3'd6});
    chk_aux(3'd2, 16'h0083);
    op({apl_pkg::OP_MOD_AUX, 8'ha0}, 8'h02, 16'h0000, 16'h0001);
    chk({seenRef, lowCnt[3:0]}, 5'h02);
    chk_aux(3'd6, 16'h0089);
    op({apl_pkg::OP_PAGE_IMM, 9'h123}, 8'h00, 16'h0000, 16'h0001);
    op({apl_pkg::OP_PAGE_MEM, 8'h45}, 8'h00, 16'hfe07, 16'h0001);
    chk({seenRead, seenAddr}, {1'b1, 9'h123, 7'h45});
    chk(seenExt, 1'b1);
    chk(dataPage, 9'h007);
    @(posedge sys_clk);
    mulProduct <= 32'h12345678;
    mulLoad    <= 1'b1;
    @(posedge sys_clk);
    mulLoad <= 1'b0;
    #1;
    chk(productReg, 32'h12345678);
    for (int i = 0; i < 5; i++) begin
      op({apl_pkg::OP_PAGE_IMM, PG[i]}, 8'h00, 16'h0000, 16'h0001);
      op({apl_pkg::OP_PROD_HIGH, 1'b0, OF[i]}, 8'h00, 16'hb000 | i[15:0], 16'h0001);
      chk(seenExt, PG[i] >= 9'h008);
      chk(seenB01, PG[i] >= 9'h004 && PG[i] <= 9'h007);
      chk(seenB2, PG[i] == 9'h000 && OF[i] >= 7'h60);
      chk(productReg, {16'hb000 | i[15:0], 16'h5678});
    end
    // pointer is 6: loading the pointed register must skip its decrement
    op({apl_pkg::OP_AUX_MEM, 3'd6, 8'h90}, 8'h00, 16'h4242, 16'h0001);
    chk(seenAddr, 16'h0089);
    chk_aux(3'd6, 16'h4242);
    op({apl_pkg::OP_AUX_MEM, 3'd1, 8'h90}, 8'h00, 16'h1357, 16'h0001);
    chk_aux(3'd6, 16'h4241);
    chk_aux(3'd1, 16'h1357);
    op({apl_pkg::OP_AUX_MEM, 3'd7, 8'h05}, 8'h01, 16'h2468, 16'h0001);
    chk(seenRef, 1'b0);
    chk_aux(3'd7, 16'h2468);
    issue({apl_pkg::OP_AUX_LONG, 3'd2, 8'h00}, 8'h01, 16'h0000);
    chk({seenRef, instrReady}, 2'b11);
    op(16'h8001, 8'h00, 16'h0000, 16'h0002);
    chk_aux(3'd2, 16'h8001);
    chk(signExtMode, 1'b1);
    op({apl_pkg::OP_STAT_ONE, 8'h10}, 8'h00, 16'h6000, 16'h0001);
    chk({auxBuffer, auxPointer, signExtMode}, {3'd3, 3'd3, 1'b0});
    issue({apl_pkg::OP_AUX_LONG, 3'd5, 8'h00}, 8'h00, 16'h0000);
    op(16'hffff, 8'h00, 16'h0000, 16'h0002);
    chk_aux(3'd5, 16'hffff);
    chk(signExtMode, 1'b0);
    op({apl_pkg::OP_STAT_ZERO, 8'h11}, 8'h00, 16'h80aa, 16'h0001);
    chk({auxPointer, dataPage}, {3'd4, 9'h0aa});
    // external fetch: busy p cycles, 2p for the two-word load
    @(posedge sys_clk);
    progExternal <= 1'b1;
    progWaits    <= 4'h2;
    op({apl_pkg::OP_AUX_SHORT, 3'd0, 8'h33}, 8'h00, 16'h0000, 16'h0001);
    chk(lowCnt, 32'd2);
    issue({apl_pkg::OP_AUX_LONG, 3'd0, 8'h00}, 8'h00, 16'h0000);
    op(16'h0c0c, 8'h00, 16'h0000, 16'h0002);
    chk(lowCnt, 32'd4);
    chk_aux(3'd0, 16'h0c0c);
    test_done();
  end
endmodule : apl_load_unit_tb
